// *** testbench/hsc_board_model.sv ***
`timescale 1ns/10ps
module hsc_board_model (
  input wire logic [3:0] strap_i,
  input wire logic susp_pin_i,
  input wire logic susp_oe_i,
  input wire logic hs_pin_i,
  input wire logic hs_oe_i,
  output logic cfg0_o,
  output logic nr_hi_o,
  output logic susp_o,
  output logic hs_o,
  output logic susp_on_o,
  output logic hs_on_o
);
  // Undriven pins rest at their strap resistor level
  assign cfg0_o = strap_i[0];
  assign nr_hi_o = strap_i[2];
  assign susp_o = susp_oe_i ? susp_pin_i : strap_i[1];
  assign hs_o = hs_oe_i ? hs_pin_i : strap_i[3];
  // LED lights when driven away from its strap level
  assign susp_on_o = susp_oe_i && susp_pin_i != strap_i[1];
  assign hs_on_o = hs_oe_i && hs_pin_i != strap_i[3];
endmodule

// *** testbench/hsc_strap_indicators_asserts.sv ***
`timescale 1ns/10ps
module hsc_strap_indicators_chk import hsc_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire hsc_wb_req_t wb_req_i,
  input wire hsc_wb_rsp_t wb_rsp_o,
  input wire logic config_select_0_i,
  input wire logic nonremovable_strap_hi_i,
  input wire logic active_suspend_indicator_i,
  input wire logic high_speed_indicator_i,
  input wire logic active_suspend_indicator_oe_o,
  input wire logic high_speed_indicator_oe_o,
  input wire hsc_hub_cfg_t hub_cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_release; $rose(nrst_i); endsequence
  sequence s_cfg_up; !hub_cfg_o.valid ##[1:3] hub_cfg_o.valid; endsequence
  a_cfg_ready: assert property (s_release |-> s_cfg_up)
    else $error("config not valid after release");
  a_method_latch: assert property ($rose(hub_cfg_o.valid) |->
    hub_cfg_o.config_method == $past({high_speed_indicator_i, config_select_0_i}, 2)) else $error("method");
  a_code_latch: assert property ($rose(hub_cfg_o.valid) |-> hub_cfg_o.nonremovable_code ==
    (hub_cfg_o.strap_enabled ? $past({nonremovable_strap_hi_i, active_suspend_indicator_i}, 2) : 2'h0))
    else $error("code latch");
  a_strap_enable: assert property (hub_cfg_o.valid |->
    hub_cfg_o.strap_enabled == STRAP_EN_BY_METHOD[hub_cfg_o.config_method]) else $error("strap enable");
  a_ports_decode: assert property (hub_cfg_o.valid |-> hub_cfg_o.nonremovable_ports ==
    {hub_cfg_o.nonremovable_code == 2'h3, hub_cfg_o.nonremovable_code[1], hub_cfg_o.nonremovable_code != 2'h0})
    else $error("ports decode");
  a_compound_flag: assert property (hub_cfg_o.valid |->
    hub_cfg_o.compound_device == (hub_cfg_o.nonremovable_code != 2'h0)) else $error("compound");
  a_cfg_hold: assert property (hub_cfg_o.valid |=> $stable(hub_cfg_o.config_method) &&
    (!hub_cfg_o.strap_enabled || $stable(hub_cfg_o.nonremovable_code))) else $error("latch moved");
  a_pins_driven: assert property (active_suspend_indicator_oe_o == hub_cfg_o.valid &&
    high_speed_indicator_oe_o == hub_cfg_o.valid) else $error("led enable");
  a_ack_pulse: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=>
    wb_rsp_o.ack ##1 !wb_rsp_o.ack) else $error("ack timing");
endmodule
bind hsc_strap_indicators hsc_strap_indicators_chk hsc_strap_indicators_chk_inst (.clk_i, .nrst_i, .wb_req_i,
  .wb_rsp_o, .config_select_0_i, .nonremovable_strap_hi_i, .active_suspend_indicator_i, .high_speed_indicator_i,
  .active_suspend_indicator_oe_o, .high_speed_indicator_oe_o, .hub_cfg_o);

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench import hsc_pkg::*;;
  logic clk_i = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] straps = 4'h0;
  hsc_wb_req_t wb_req = '0;
  hsc_wb_rsp_t wb_rsp;
  hsc_hub_state_t hub_state = '0;
  hsc_hub_cfg_t cfg;
  logic cfg0, nr_hi, susp_in, susp_out, susp_oe, hs_in, hs_out, hs_oe, susp_on, hs_on, en;
  logic [1:0] m, c;
  logic [31:0] q, st;
  hsc_hub_cfg_t exp_c;
  int errors = 0;
  int checked = 0;
  always #4 clk_i = ~clk_i;
  hsc_strap_indicators hsc_strap_indicators_inst (.clk_i, .nrst_i(nrst), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .config_select_0_i(cfg0), .nonremovable_strap_hi_i(nr_hi), .active_suspend_indicator_i(susp_in),
    .active_suspend_indicator_o(susp_out), .active_suspend_indicator_oe_o(susp_oe), .high_speed_indicator_i(hs_in),
    .high_speed_indicator_o(hs_out), .high_speed_indicator_oe_o(hs_oe), .hub_state_i(hub_state), .hub_cfg_o(cfg));
  hsc_board_model hsc_board_model_inst (.strap_i(straps), .susp_pin_i(susp_out), .susp_oe_i(susp_oe),
    .hs_pin_i(hs_out), .hs_oe_i(hs_oe), .cfg0_o(cfg0), .nr_hi_o(nr_hi), .susp_o(susp_in), .hs_o(hs_in),
    .susp_on_o(susp_on), .hs_on_o(hs_on));
  function automatic hsc_hub_cfg_t exp_cfg(input logic [1:0] mm, input logic [1:0] cc);
    return '{1'b1, mm, STRAP_EN_BY_METHOD[mm], cc, {cc == 2'h3, cc[1], cc != 2'h0}, cc != 2'h0};
  endfunction
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {24'h0, a}, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask
  task automatic do_reset(input int n);
    nrst <= 1'b0;
    repeat (n) @(posedge clk_i);
    `CHK({cfg, susp_oe, hs_oe, wb_rsp.ack}, 13'h0)
    nrst <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    do_reset(4);
    for (int s = 0; s < 16; s++) begin
      straps <= 4'(s);
      if (s > 0) do_reset(RESET_MIN_CYC);
      m = {straps[3], straps[0]};
      en = STRAP_EN_BY_METHOD[m];
      `CHK(cfg, exp_cfg(m, en ? straps[2:1] : 2'h0))
      bus(1'b1, ADDR_STRAP, 32'hff);
      bus(1'b0, ADDR_STRAP, 32'h0);
      `CHK(q[5:0], {straps[1], straps[3], straps[2:1], straps[3], straps[0]})
      c = en ? straps[2:1] : 2'h3;
      bus(1'b1, ADDR_CONTROL, 32'h103);
      straps <= straps ^ 4'h5;
      repeat (2) @(posedge clk_i);
      `CHK(cfg, exp_cfg(m, c))
      straps <= straps ^ 4'h5;
      for (int h = 0; h < 16; h++) begin
        hub_state <= hsc_hub_state_t'(4'(h));
        repeat (3) @(posedge clk_i);
        `CHK({hs_on, susp_on}, {h[1] & h[0], h[3] & !h[2]})
      end
      bus(1'b1, ADDR_CONTROL, 32'h0);
      repeat (3) @(posedge clk_i);
      `CHK({hs_on, susp_on}, 2'h0)
      hub_state <= '0;
      bus(1'b1, ADDR_CONTROL, 32'h300);
      repeat (3) @(posedge clk_i);
      `CHK({hs_on, susp_on}, 2'h3)
    end
    hub_state <= hsc_hub_state_t'(4'hb);
    do_reset(RESET_MIN_CYC);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    `CHK(q, 32'h100)
    exp_c = exp_cfg(m, en ? straps[2:1] : 2'h0);
    st = {20'h0, 3'h7, exp_c.nonremovable_ports, exp_c.compound_device, exp_c.strap_enabled,
      exp_c.nonremovable_code, exp_c.config_method};
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q, st)
    bus(1'b0, ADDR_ID, 32'h0);
    `CHK(q, BLOCK_ID)
    bus(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    give_verdict();
  end
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule

// *** verilog/hsc_led_pin.sv ***
`timescale 1ns/10ps
module hsc_led_pin import hsc_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic lit_i,
  input wire logic active_low_i,
  output logic pin_o,
  output logic pin_oe_o
);

  typedef struct packed {
    logic oe;
    logic out;
  } hsc_led_state_t;

  hsc_led_state_t state_reg;
  hsc_led_state_t state_next;

  // Pin stays an input until its strap level has been taken
  always_comb begin
    state_next.oe = enable_i;
    state_next.out = enable_i ? (lit_i ^ active_low_i) : 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_o = state_reg.out;
  assign pin_oe_o = state_reg.oe;

endmodule

// *** verilog/hsc_pkg.sv ***
package hsc_pkg;

  // Clock and reset timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STRAP = 8'h08;
  localparam logic [7:0] ADDR_ID = 8'h0c;

  // Identification word, value is arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;

  // One bit per configuration method: set where the strap option is enabled
  localparam logic [3:0] STRAP_EN_BY_METHOD = 4'h1;

  // Control register fields
  localparam int CTRL_SW_CODE_LSB = 0;
  localparam int CTRL_IND_EN_BIT = 8;
  localparam int CTRL_LED_TEST_BIT = 9;
  localparam logic [1:0] CTRL_SW_CODE_RST = 2'h0;
  localparam logic CTRL_IND_EN_RST = 1'b1;
  localparam logic CTRL_LED_TEST_RST = 1'b0;

  // Status register fields
  localparam int STAT_METHOD_LSB = 0;
  localparam int STAT_CODE_LSB = 2;
  localparam int STAT_STRAP_EN_BIT = 4;
  localparam int STAT_COMPOUND_BIT = 5;
  localparam int STAT_PORTS_LSB = 6;
  localparam int STAT_HS_LIT_BIT = 9;
  localparam int STAT_SUSP_LIT_BIT = 10;
  localparam int STAT_VALID_BIT = 11;

  // Strap register fields
  localparam int STRAP_CFG0_BIT = 0;
  localparam int STRAP_CFG1_BIT = 1;
  localparam int STRAP_NR_LO_BIT = 2;
  localparam int STRAP_NR_HI_BIT = 3;
  localparam int STRAP_HS_POL_BIT = 4;
  localparam int STRAP_SUSP_POL_BIT = 5;

  // Non-removable code values and port masks
  localparam logic [1:0] NONREM_NONE = 2'h0;
  localparam logic [1:0] NONREM_P1 = 2'h1;
  localparam logic [1:0] NONREM_P12 = 2'h2;
  localparam logic [1:0] NONREM_P123 = 2'h3;
  localparam logic [2:0] PORTS_NONE = 3'h0;
  localparam logic [2:0] PORTS_P1 = 3'h1;
  localparam logic [2:0] PORTS_P12 = 3'h3;
  localparam logic [2:0] PORTS_P123 = 3'h7;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } hsc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } hsc_wb_rsp_t;

  typedef struct packed {
    logic configured;
    logic suspended;
    logic connected;
    logic high_speed;
  } hsc_hub_state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] config_method;
    logic strap_enabled;
    logic [1:0] nonremovable_code;
    logic [2:0] nonremovable_ports;
    logic compound_device;
  } hsc_hub_cfg_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] sw_code;
    logic ind_en;
    logic led_test;
    logic hs_lit;
    logic susp_lit;
    hsc_hub_cfg_t cfg;
  } hsc_top_state_t;

endpackage

// *** verilog/hsc_strap_indicators.sv ***
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module hsc_strap_indicators import hsc_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire hsc_wb_req_t wb_req_i,
  output hsc_wb_rsp_t wb_rsp_o,
  input wire logic config_select_0_i,
  input wire logic nonremovable_strap_hi_i,
  input wire logic active_suspend_indicator_i,
  output logic active_suspend_indicator_o,
  output logic active_suspend_indicator_oe_o,
  input wire logic high_speed_indicator_i,
  output logic high_speed_indicator_o,
  output logic high_speed_indicator_oe_o,
  input wire hsc_hub_state_t hub_state_i,
  output hsc_hub_cfg_t hub_cfg_o
);

  hsc_top_state_t state_reg;
  hsc_top_state_t state_next;

  logic [1:0] cfg_sel;
  logic [1:0] strap_code;
  logic straps_valid;

  logic strap_en;
  logic [1:0] eff_code;
  logic [2:0] ports;
  logic hs_active_low;
  logic susp_active_low;
  logic hs_drive;
  logic susp_drive;
  logic req;
  logic addr_hit_status;
  logic addr_hit_control;
  logic addr_hit_strap;
  logic addr_hit_id;
  logic [31:0] status_word;
  logic [31:0] strap_word;
  logic [31:0] control_word;
  logic rd_req;
  logic wr_req;
  logic wr_control;
  logic wr_lane_code;
  logic wr_lane_ind;
  logic [31:0] rd_word;
  logic hs_lit_next;
  logic susp_lit_next;
  logic compound_next;
  hsc_hub_cfg_t cfg_next;

  // Select pins share the serial clock pin and the high-speed LED pin
  hsc_strap_latch #(
    .WIDTH(2)
  ) u_cfg_latch (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pins_i({high_speed_indicator_i, config_select_0_i}),
    .value_o(cfg_sel),
    .captured_o(straps_valid)
  );

  // Non-removable straps share the serial data pin and the suspend LED pin
  hsc_strap_latch #(
    .WIDTH(2)
  ) u_nonrem_latch (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pins_i({nonremovable_strap_hi_i, active_suspend_indicator_i}),
    .value_o(strap_code),
    .captured_o()
  );

  // Strap code only counts where the selected method enables it
  always_comb begin
    strap_en = STRAP_EN_BY_METHOD[cfg_sel];
    eff_code = strap_en ? strap_code : state_reg.sw_code;
  end

  // Port mask of the effective code
  always_comb begin
    case (eff_code)
      NONREM_NONE: ports = PORTS_NONE;
      NONREM_P1: ports = PORTS_P1;
      NONREM_P12: ports = PORTS_P12;
      default: ports = PORTS_P123;
    endcase
  end

  // Configuration result; method frozen once the straps are held, code follows sw_code where straps are disabled
  always_comb begin
    compound_next = straps_valid & (eff_code != NONREM_NONE);
    cfg_next.valid = straps_valid;
    cfg_next.config_method = cfg_sel;
    cfg_next.strap_enabled = strap_en;
    cfg_next.nonremovable_code = eff_code;
    cfg_next.nonremovable_ports = ports;
    cfg_next.compound_device = compound_next;
  end

  // Polarity follows the level each shared pin carried at release
  assign susp_active_low = strap_code[0];
  assign hs_active_low = cfg_sel[1];

  assign hs_drive = state_reg.led_test | state_reg.hs_lit;
  assign susp_drive = state_reg.led_test | state_reg.susp_lit;

  // Indicator levels before polarity
  assign hs_lit_next = state_reg.ind_en & hub_state_i.connected & hub_state_i.high_speed;
  assign susp_lit_next = state_reg.ind_en & hub_state_i.configured & ~hub_state_i.suspended;

  // Register view words
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_METHOD_LSB +: 2] = state_reg.cfg.config_method;
    status_word[STAT_CODE_LSB +: 2] = state_reg.cfg.nonremovable_code;
    status_word[STAT_STRAP_EN_BIT] = state_reg.cfg.strap_enabled;
    status_word[STAT_COMPOUND_BIT] = state_reg.cfg.compound_device;
    status_word[STAT_PORTS_LSB +: 3] = state_reg.cfg.nonremovable_ports;
    status_word[STAT_HS_LIT_BIT] = state_reg.hs_lit;
    status_word[STAT_SUSP_LIT_BIT] = state_reg.susp_lit;
    status_word[STAT_VALID_BIT] = state_reg.cfg.valid;
  end

  always_comb begin
    strap_word = 32'h0000_0000;
    strap_word[STRAP_CFG0_BIT] = cfg_sel[0];
    strap_word[STRAP_CFG1_BIT] = cfg_sel[1];
    strap_word[STRAP_NR_LO_BIT] = strap_code[0];
    strap_word[STRAP_NR_HI_BIT] = strap_code[1];
    strap_word[STRAP_HS_POL_BIT] = hs_active_low;
    strap_word[STRAP_SUSP_POL_BIT] = susp_active_low;
  end

  always_comb begin
    control_word = 32'h0000_0000;
    control_word[CTRL_SW_CODE_LSB +: 2] = state_reg.sw_code;
    control_word[CTRL_IND_EN_BIT] = state_reg.ind_en;
    control_word[CTRL_LED_TEST_BIT] = state_reg.led_test;
  end

  // Bus decode; unmapped addresses are acknowledged, read zero, ignore writes
  assign req = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
  always_comb begin
    addr_hit_status = 1'b0;
    addr_hit_control = 1'b0;
    addr_hit_strap = 1'b0;
    addr_hit_id = 1'b0;
    if (wb_req_i.adr == {24'h00_0000, ADDR_STATUS}) begin
      addr_hit_status = 1'b1;
    end else if (wb_req_i.adr == {24'h00_0000, ADDR_CONTROL}) begin
      addr_hit_control = 1'b1;
    end else if (wb_req_i.adr == {24'h00_0000, ADDR_STRAP}) begin
      addr_hit_strap = 1'b1;
    end else if (wb_req_i.adr == {24'h00_0000, ADDR_ID}) begin
      addr_hit_id = 1'b1;
    end
  end

  assign rd_req = req & ~wb_req_i.we;
  assign wr_req = req & wb_req_i.we;
  assign wr_control = wr_req & addr_hit_control;
  assign wr_lane_code = wr_control & wb_req_i.sel[0];
  assign wr_lane_ind = wr_control & wb_req_i.sel[1];

  // Zero outside a read, so the bus sees zero between answers
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_req) begin
      if (addr_hit_status) begin
        rd_word = status_word;
      end else if (addr_hit_control) begin
        rd_word = control_word;
      end else if (addr_hit_strap) begin
        rd_word = strap_word;
      end else if (addr_hit_id) begin
        rd_word = BLOCK_ID;
      end else begin
        rd_word = 32'h0000_0000;
      end
    end
  end

  always_comb begin
    state_next = state_reg;

    state_next.cfg = cfg_next;
    state_next.hs_lit = hs_lit_next;
    state_next.susp_lit = susp_lit_next;

    // Wishbone classic slave, one wait state
    state_next.ack = req;
    state_next.rdata = rd_word;
    if (wr_lane_code) begin
      state_next.sw_code = wb_req_i.dat[CTRL_SW_CODE_LSB +: 2];
    end
    if (wr_lane_ind) begin
      state_next.ind_en = wb_req_i.dat[CTRL_IND_EN_BIT];
      state_next.led_test = wb_req_i.dat[CTRL_LED_TEST_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.sw_code <= CTRL_SW_CODE_RST;
      state_reg.ind_en <= CTRL_IND_EN_RST;
      state_reg.led_test <= CTRL_LED_TEST_RST;
      state_reg.hs_lit <= 1'b0;
      state_reg.susp_lit <= 1'b0;
      state_reg.cfg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // LED drivers on the shared strap pins
  hsc_led_pin u_hs_led (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(straps_valid),
    .lit_i(hs_drive),
    .active_low_i(hs_active_low),
    .pin_o(high_speed_indicator_o),
    .pin_oe_o(high_speed_indicator_oe_o)
  );

  hsc_led_pin u_susp_led (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(straps_valid),
    .lit_i(susp_drive),
    .active_low_i(susp_active_low),
    .pin_o(active_suspend_indicator_o),
    .pin_oe_o(active_suspend_indicator_oe_o)
  );

  assign wb_rsp_o = '{ack: state_reg.ack, dat: state_reg.rdata};
  assign hub_cfg_o = state_reg.cfg;

endmodule

// *** verilog/hsc_strap_latch.sv ***
`timescale 1ns/10ps
module hsc_strap_latch import hsc_pkg::*; #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] value_o,
  output logic captured_o
);

  typedef struct packed {
    logic captured;
    logic [WIDTH-1:0] value;
  } hsc_latch_state_t;

  hsc_latch_state_t state_reg;
  hsc_latch_state_t state_next;

  // Sample once at the first edge after release, then hold until next reset
  always_comb begin
    state_next = state_reg;
    if (!state_reg.captured) begin
      state_next.captured = 1'b1;
      state_next.value = pins_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value_o = state_reg.value;
  assign captured_o = state_reg.captured;

endmodule
